//--- src/sfr_flash_cmd.sv
// Command interpreter of a serial flash slave port with an APB side port.
// Assumes pins arrive asynchronously and the link clock is at most an
// eighth of clk_sys; the APB master sits on clk_sys.
`timescale 1ns/1ns
`default_nettype none

module sfr_flash_cmd
	import sfr_pkg::*;
#(
	parameter int MEM_AW              = 12,
	parameter int STATUS_WRITE_CYC    = STATUS_WRITE_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        cs_n_pin,
	input  wire logic        sclk_pin,
	input  wire logic [3:0]  lane_in,
	output var  sfr_lanes_t  lanes_r,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata_r,
	output logic             pready_r,
	output logic             pslverr_r
);

	// ==========================================================
	// Pin synchronisers: {cs_n, sclk, lanes}.
	logic [5:0] sync1_r;
	logic [5:0] sync2_r;
	logic [5:0] sync3_r;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sync1_r <= 6'h3F;
			sync2_r <= 6'h3F;
			sync3_r <= 6'h3F;
		end else begin
			sync1_r <= {cs_n_pin, sclk_pin, lane_in};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	wire       cs_low   = ~sync2_r[5];
	wire       cs_fall  = ~sync2_r[5] & sync3_r[5];
	wire       cs_rise  = sync2_r[5] & ~sync3_r[5];
	wire       sck_rise = cs_low & sync2_r[4] & ~sync3_r[4];
	wire       sck_fall = cs_low & ~sync2_r[4] & sync3_r[4];
	wire [3:0] lanes_s  = sync2_r[3:0];

	// ==========================================================
	// Storage and state.
	logic [7:0]          mem [0:(1<<MEM_AW)-1];
	sfr_state_t          st_r;
	logic [4:0]          cnt_r;
	logic [23:0]         sh_r;
	logic [23:0]         addr_r;
	logic                aw2_r;
	logic [1:0]          dw_r;
	logic                dummy_r;
	logic                mode_r;
	logic                cont_r;
	logic                srsel_r;
	logic [7:0]          obyte_r;
	logic [3:0]          rem_r;
	logic [7:0]          cmd_r;
	logic [15:0]         wsr_r;
	logic [4:0]          wcnt_r;
	logic [15:0]         sr_r;
	logic                wel_r;
	logic                vwe_r;
	logic                wt_act_r;
	logic                wt_nv_r;
	logic [15:0]         wt_val_r;
	logic [TIMER_W-1:0]  wt_cnt_r;
	logic                ext_busy_r;
	logic [MEM_AW-1:0]   mem_addr_r;

	// ==========================================================
	// Decode helpers.
	wire        busy      = (wt_act_r & wt_nv_r) | ext_busy_r;
	wire [15:0] sr_view   = {sr_r[15:2], wel_r, busy};
	wire [23:0] sh_in     = aw2_r ? {sh_r[21:0], lanes_s[1:0]}
	                              : {sh_r[22:0], lanes_s[0]};
	wire [7:0]  cmd_in    = {sh_r[6:0], lanes_s[0]};
	wire [4:0]  addr_last = aw2_r ? 5'd11 : 5'd23;
	wire [7:0]  mem_q     = mem[addr_r[MEM_AW-1:0]];
	wire [7:0]  sr_byte   = srsel_r ? sr_view[15:8] : sr_view[7:0];
	wire [7:0]  src_byte  = (st_r == ST_SROUT) ? sr_byte : mem_q;
	wire [7:0]  cur       = (rem_r == 4'd0) ? src_byte : obyte_r;
	wire [3:0]  rem_len   = (dw_r == 2'd0) ? 4'd8 :
	                        (dw_r == 2'd1) ? 4'd4 : 4'd2;
	wire        out_phase = (st_r == ST_DATA) | (st_r == ST_SROUT);
	wire        arm_exec  = cs_rise & (st_r == ST_ARMED);
	// In continuous mode the reset byte lands in the address phase, so
	// eight clocks of ones on lane 0 followed by select high end the mode.
	wire        crm_lane0 = &{sh_r[14], sh_r[12], sh_r[10], sh_r[8],
	                          sh_r[6], sh_r[4], sh_r[2], sh_r[0]};
	wire        crm_cont  = (st_r == ST_ADDR) & aw2_r & (cnt_r == 5'd8) &
	                        crm_lane0;
	wire        sw_len_ok = (wcnt_r == 5'd8) | (wcnt_r == 5'd16);
	wire        sw_exec   = cs_rise & (st_r == ST_SRIN) & sw_len_ok &
	                        ~busy & (wel_r | vwe_r);
	wire [15:0] sw_word   = (wcnt_r == 5'd16) ? {wsr_r[7:0], wsr_r[15:8]}
	                        : {sr_r[15:8] & ~SR_SHORT_CLEAR[15:8],
	                           wsr_r[7:0]};
	wire [15:0] otp_mask  = wel_r ? SR_OTP_NV_MASK : SR_OTP_V_MASK;
	wire [15:0] sw_new    = (sw_word & SR_WRITABLE_MASK) |
	                        (sr_r & otp_mask);

	// ==========================================================
	// Frame sequencer.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r    <= ST_IDLE;
			cnt_r   <= 5'd0;
			sh_r    <= 24'h00_0000;
			addr_r  <= 24'h00_0000;
			aw2_r   <= 1'b0;
			dw_r    <= 2'd0;
			dummy_r <= 1'b0;
			mode_r  <= 1'b0;
			cont_r  <= 1'b0;
			srsel_r <= 1'b0;
			cmd_r   <= 8'h00;
			wsr_r   <= 16'h0000;
			wcnt_r  <= 5'd0;
		end else if (cs_rise) begin
			st_r <= ST_IDLE;
			if ((arm_exec && cmd_r == OP_CRMR) || crm_cont)
				cont_r <= 1'b0;
		end else if (cs_fall) begin
			cnt_r  <= 5'd0;
			wcnt_r <= 5'd0;
			if (cont_r && !busy) begin
				st_r    <= ST_ADDR;
				aw2_r   <= 1'b1;
				dw_r    <= 2'd1;
				dummy_r <= 1'b0;
				mode_r  <= 1'b1;
			end else if (cont_r) begin
				st_r <= ST_IGN;
			end else begin
				st_r  <= ST_CMD;
				aw2_r <= 1'b0;
			end
		end else if (sck_rise) begin
			sh_r  <= sh_in;
			cnt_r <= cnt_r + 5'd1;
			unique case (st_r)
				ST_CMD: begin
					if (cnt_r == 5'd7) begin
						cnt_r   <= 5'd0;
						cmd_r   <= cmd_in;
						dummy_r <= 1'b0;
						mode_r  <= 1'b0;
						dw_r    <= 2'd0;
						st_r    <= ST_IGN;
						unique case (cmd_in)
							OP_READ: if (!busy) st_r <= ST_ADDR;
							OP_FAST: if (!busy) begin
								st_r    <= ST_ADDR;
								dummy_r <= 1'b1;
							end
							OP_DOUT: if (!busy) begin
								st_r    <= ST_ADDR;
								dummy_r <= 1'b1;
								dw_r    <= 2'd1;
							end
							OP_QOUT: if (!busy && sr_r[SR_QE]) begin
								st_r    <= ST_ADDR;
								dummy_r <= 1'b1;
								dw_r    <= 2'd2;
							end
							OP_DIO: if (!busy) begin
								st_r   <= ST_ADDR;
								aw2_r  <= 1'b1;
								mode_r <= 1'b1;
								dw_r   <= 2'd1;
							end
							OP_RDSR1, OP_RDSR2: begin
								st_r    <= ST_SROUT;
								srsel_r <= (cmd_in == OP_RDSR2);
							end
							OP_WRSR: if (!busy) st_r <= ST_SRIN;
							OP_WREN, OP_VWREN, OP_WRDI, OP_CRMR:
								if (!busy) st_r <= ST_ARMED;
							default: st_r <= ST_IGN;
						endcase
					end
				end
				ST_ADDR: begin
					if (cnt_r == addr_last) begin
						cnt_r  <= 5'd0;
						addr_r <= sh_in;
						st_r   <= mode_r ? ST_MODE :
						          dummy_r ? ST_DUMMY : ST_DATA;
					end
				end
				ST_MODE: begin
					if (cnt_r == 5'(MODE_CLOCKS_DIO - 1)) begin
						cnt_r  <= 5'd0;
						st_r   <= ST_DATA;
						cont_r <= (sh_in[5:4] == CONT_SELECT);
					end
				end
				ST_DUMMY: begin
					if (cnt_r == 5'(DUMMY_CLOCKS - 1)) begin
						cnt_r <= 5'd0;
						st_r  <= ST_DATA;
					end
				end
				ST_SRIN: begin
					wsr_r <= {wsr_r[14:0], lanes_s[0]};
					if (wcnt_r != 5'd31)
						wcnt_r <= wcnt_r + 5'd1;
				end
				ST_ARMED: st_r <= ST_IGN;
				ST_IDLE, ST_DATA, ST_SROUT, ST_IGN: cnt_r <= 5'd0;
				default: st_r <= ST_IGN;
			endcase
		end else if (sck_fall && st_r == ST_DATA && rem_r == 4'd0) begin
			addr_r <= addr_r + 24'd1;
		end
	end

	// ==========================================================
	// Output lanes change on falling link edges; select high or a state other than data or status out clears them.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lanes_r <= '0;
			obyte_r <= 8'h00;
			rem_r   <= 4'd0;
		end else if (!cs_low || !out_phase) begin
			lanes_r <= '0;
			rem_r   <= 4'd0;
		end else if (sck_fall) begin
			rem_r <= ((rem_r == 4'd0) ? rem_len : rem_r) - 4'd1;
			unique case (dw_r)
				2'd1: begin
					lanes_r <= '{dout: {2'b00, cur[7:6]}, oe: 4'b0011};
					obyte_r <= {cur[5:0], 2'b00};
				end
				2'd2: begin
					lanes_r <= '{dout: cur[7:4], oe: 4'b1111};
					obyte_r <= {cur[3:0], 4'h0};
				end
				default: begin
					lanes_r <= '{dout: {2'b00, cur[7], 1'b0},
					             oe: 4'b0010};
					obyte_r <= {cur[6:0], 1'b0};
				end
			endcase
		end
	end

	// ==========================================================
	// Status register, enable latches and the self-timed update.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sr_r     <= SR_RESET;
			wel_r    <= 1'b0;
			vwe_r    <= 1'b0;
			wt_act_r <= 1'b0;
			wt_nv_r  <= 1'b0;
			wt_val_r <= SR_RESET;
			wt_cnt_r <= '0;
		end else if (wt_act_r) begin
			if (wt_cnt_r == '0) begin
				wt_act_r <= 1'b0;
				sr_r     <= wt_val_r;
				if (wt_nv_r)
					wel_r <= 1'b0;
			end else begin
				wt_cnt_r <= wt_cnt_r - 1'b1;
			end
		end else if (sw_exec) begin
			wt_act_r <= 1'b1;
			wt_val_r <= sw_new;
			wt_nv_r  <= wel_r;
			if (wel_r)
				wt_cnt_r <= TIMER_W'(STATUS_WRITE_CYC - 1);
			else begin
				wt_cnt_r <= TIMER_W'(VOLATILE_UPDATE_CYCLES - 1);
				vwe_r    <= 1'b0;
			end
		end else if (arm_exec) begin
			if (cmd_r == OP_WREN)
				wel_r <= 1'b1;
			if (cmd_r == OP_VWREN)
				vwe_r <= 1'b1;
			if (cmd_r == OP_WRDI) begin
				wel_r <= 1'b0;
				vwe_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// APB slave: one wait state, so every answer comes from a flop.
	wire        apb_acc  = psel & penable;
	wire        apb_done = apb_acc & pready_r;
	wire        hit_st   = (paddr == REG_STATUS);
	wire        hit_ctl  = (paddr == REG_CTRL);
	wire        hit_ma   = (paddr == REG_MEM_ADDR);
	wire        hit_md   = (paddr == REG_MEM_DATA);
	wire        mapped   = hit_st | hit_ctl | hit_ma | hit_md;
	wire [31:0] rd_mux   =
		hit_st  ? {13'h0000, wt_act_r, cont_r, vwe_r, sr_view} :
		hit_ctl ? {31'h0000_0000, ext_busy_r} :
		hit_ma  ? {{(32-MEM_AW){1'b0}}, mem_addr_r} :
		hit_md  ? {24'h00_0000, mem[mem_addr_r]} : 32'h0000_0000;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			prdata_r   <= 32'h0000_0000;
			ext_busy_r <= CTRL_RESET[0];
			mem_addr_r <= '0;
		end else begin
			pready_r  <= apb_acc & ~pready_r;
			pslverr_r <= apb_acc & ~pready_r & ~mapped;
			if (apb_acc && !pready_r)
				prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
			if (apb_done && pwrite && hit_ctl)
				ext_busy_r <= pwdata[0];
			if (apb_done && pwrite && hit_ma)
				mem_addr_r <= pwdata[MEM_AW-1:0];
			else if (apb_done && hit_md)
				mem_addr_r <= mem_addr_r + 1'b1;
		end
	end

	// The array keeps no reset; software loads it over APB.
	always_ff @(posedge clk_sys) begin
		if (apb_done && pwrite && hit_md)
			mem[mem_addr_r] <= pwdata[7:0];
	end

endmodule : sfr_flash_cmd
`default_nettype wire

//--- src/sfr_pkg.sv
// Constants, types and status layout for the serial flash command block.
// Assumes a 25 MHz system clock and an APB host for the side registers.
package sfr_pkg;

	// ==========================================================
	// Timing.
	localparam int CLK_PERIOD_NS           = 40;
	localparam int STATUS_WRITE_TIME_US    = 10;
	localparam int STATUS_WRITE_CYCLES     =
		(STATUS_WRITE_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int VOLATILE_UPDATE_TIME_NS = 50;
	localparam int VOLATILE_UPDATE_CYCLES  =
		(VOLATILE_UPDATE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
		VOLATILE_UPDATE_TIME_NS / CLK_PERIOD_NS;
	localparam int TIMER_W                 = 16;

	// ==========================================================
	// Opcodes.
	localparam logic [7:0] OP_WREN   = 8'h06;
	localparam logic [7:0] OP_VWREN  = 8'h50;
	localparam logic [7:0] OP_WRDI   = 8'h04;
	localparam logic [7:0] OP_RDSR1  = 8'h05;
	localparam logic [7:0] OP_RDSR2  = 8'h35;
	localparam logic [7:0] OP_WRSR   = 8'h01;
	localparam logic [7:0] OP_READ   = 8'h03;
	localparam logic [7:0] OP_FAST   = 8'h0B;
	localparam logic [7:0] OP_DOUT   = 8'h3B;
	localparam logic [7:0] OP_QOUT   = 8'h6B;
	localparam logic [7:0] OP_DIO    = 8'hBB;
	localparam logic [7:0] OP_CRMR   = 8'hFF;

	// ==========================================================
	// Frame shape.
	localparam int         DUMMY_CLOCKS   = 8;
	localparam int         MODE_CLOCKS_DIO = 4;
	localparam logic [1:0] CONT_SELECT    = 2'b10;

	// ==========================================================
	// Status word: bit 0 busy, bit 1 write enable latch.
	localparam int          SR_QE            = 9;
	localparam logic [15:0] SR_RESET         = 16'h0000;
	localparam logic [15:0] SR_WRITABLE_MASK = 16'h7FFC;
	localparam logic [15:0] SR_OTP_NV_MASK   = 16'h3C00;
	localparam logic [15:0] SR_OTP_V_MASK    = 16'h3D00;
	localparam logic [15:0] SR_SHORT_CLEAR   = 16'h4300;

	// ==========================================================
	// APB map.
	localparam logic [7:0]  REG_STATUS   = 8'h00;
	localparam logic [7:0]  REG_CTRL     = 8'h04;
	localparam logic [7:0]  REG_MEM_ADDR = 8'h08;
	localparam logic [7:0]  REG_MEM_DATA = 8'h0C;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

	typedef struct packed {
		logic [3:0] dout;
		logic [3:0] oe;
	} sfr_lanes_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_CMD   = 4'b0001,
		ST_ADDR  = 4'b0011,
		ST_MODE  = 4'b0010,
		ST_DUMMY = 4'b0110,
		ST_DATA  = 4'b0111,
		ST_SROUT = 4'b0101,
		ST_SRIN  = 4'b0100,
		ST_ARMED = 4'b1100,
		ST_IGN   = 4'b1101
	} sfr_state_t;

endpackage : sfr_pkg

//--- testbench/sfr_flash_cmd_monitor.sv
// Checker on the pins and APB port of the flash command block.
// Assumes one clock domain, clk_sys, with synchronous rst.
`timescale 1ns/1ns
`default_nettype none
module sfr_flash_cmd_monitor
	import sfr_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        cs_n_pin,
	input wire logic        sclk_pin,
	input wire logic [3:0]  lane_in,
	input wire sfr_lanes_t  lanes_r,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata_r,
	input wire logic        pready_r,
	input wire logic        pslverr_r
);
	// ==========
	// Pin and bus properties.
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_sel_up;
		$rose(cs_n_pin) ##1 cs_n_pin [*7];
	endsequence
	property p_idle_quiet;
		s_sel_up |-> lanes_r.oe == 4'h0;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("lanes driven after select high");
	property p_in_frame;
		lanes_r.oe != 4'h0 |-> !$past(cs_n_pin, 5);
	endproperty
	a_in_frame: assert property (p_in_frame)
		else $error("lanes driven outside a frame");
	// The link clock is slow, so a launch lands while it is still low.
	property p_fall_launch;
		$changed(lanes_r.dout) && lanes_r.oe != 4'h0
			|-> !sclk_pin && !$past(sclk_pin, 2);
	endproperty
	a_fall_launch: assert property (p_fall_launch)
		else $error("lane data changed outside the low phase");
	property p_rise_launch;
		$rose(|lanes_r.oe) |-> !sclk_pin && !cs_n_pin;
	endproperty
	a_rise_launch: assert property (p_rise_launch)
		else $error("lane drive began on a wrong edge");
	property p_lane_shape;
		lanes_r.oe inside {4'h0, 4'h2, 4'h3, 4'hF};
	endproperty
	a_lane_shape: assert property (p_lane_shape)
		else $error("lane enable pattern not a read width");
	property p_reset_out;
		$fell(rst) |-> lanes_r.oe == 4'h0 && !pready_r;
	endproperty
	a_reset_out: assert property (p_reset_out)
		else $error("outputs active right after reset");
	property p_ready_cause;
		pready_r |-> $past(psel && penable) && psel;
	endproperty
	a_ready_cause: assert property (p_ready_cause)
		else $error("ready without an access");
	property p_err_ready;
		pslverr_r |-> pready_r;
	endproperty
	a_err_ready: assert property (p_err_ready)
		else $error("error without ready");
endmodule : sfr_flash_cmd_monitor

bind sfr_flash_cmd sfr_flash_cmd_monitor u_mon (
	.clk_sys, .rst, .cs_n_pin, .sclk_pin, .lane_in, .lanes_r,
	.psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata_r, .pready_r, .pslverr_r
);
`default_nettype wire

//--- testbench/sfr_flash_cmd_tb.sv
// Bench for the flash command block: APB tasks and an SPI host model.
// Assumes the host model owns select, link clock and host lane drive.
`timescale 1ns/1ns
`default_nettype none
module sfr_flash_cmd_tb
	import sfr_pkg::*;
;
	logic        clk_sys   = 1'b0;
	logic        rst       = 1'b1;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h0000_0000;
	logic        tgl       = 1'b0;
	logic        seen_oe   = 1'b0;
	int          error_cnt = 0;
	int          tests_run = 0;
	wire logic        cs_n;
	wire logic        sclk;
	wire logic [3:0]  h_do;
	wire logic [3:0]  h_oe;
	wire logic [3:0]  lane_in;
	wire sfr_lanes_t  lanes_r;
	wire logic [31:0] prdata_r;
	wire logic        pready_r;
	wire logic        pslverr_r;

	// An undriven lane toggles so a stale value can never pass.
	assign lane_in = (lanes_r.oe & lanes_r.dout) | (~lanes_r.oe & h_oe & h_do)
		| (~lanes_r.oe & ~h_oe & {4{tgl}});
	sfr_spi_host u_h (.clk_sys, .lane_in, .cs_n, .sclk, .h_do, .h_oe);
	sfr_flash_cmd #(.STATUS_WRITE_CYC(1000)) dut (
		.clk_sys, .rst, .cs_n_pin(cs_n), .sclk_pin(sclk), .lane_in,
		.lanes_r, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata_r, .pready_r, .pslverr_r);

	// ==========
	// Clock, watchdog and tasks.
	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) tgl <= ~tgl;
	always @(posedge clk_sys) if (lanes_r.oe != 4'h0) seen_oe <= 1'b1;
	initial begin
		#2_000_000;
		error_cnt++;
		finish_test();
	end
	task automatic finish_test();
		if (error_cnt == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] s, x);
		tests_run++;
		if (s !== x) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, x, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk_sys);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready_r !== 1'b1);
		q = prdata_r;
		e = pslverr_r;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, x);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		chk("reg", q & m, x);
	endtask : rdc
	task automatic idle();
		logic [31:0] q = 32'h0000_0001;
		logic        e;
		for (int k = 0; k < 80 && q[0] !== 1'b0; k++) begin
			repeat (20) @(posedge clk_sys);
			apb(1'b0, REG_STATUS, 32'h0000_0000, q, e);
		end
	endtask : idle
	task automatic cmd(input logic [7:0] op, input int nb, input logic [15:0] v);
		logic [31:0] q;
		u_h.start();
		u_h.xfer(8, 1, 32'(op), 1'b0, q);
		if (nb > 0) u_h.xfer(nb, 1, 32'(v), 1'b0, q);
		u_h.stop();
	endtask : cmd
	task automatic rd(input logic opc, input logic [7:0] op, input int aw, dm,
		w, nb, input logic [7:0] md, output logic [31:0] q);
		seen_oe = 1'b0;
		u_h.start();
		if (opc) u_h.xfer(8, 1, 32'(op), 1'b0, q);
		u_h.xfer(24, aw, 32'h0000_0010, 1'b0, q);
		if (aw == 2) u_h.xfer(8, 2, 32'(md), 1'b0, q);
		if (dm > 0) u_h.xfer(dm, 1, 32'h0000_0000, 1'b1, q);
		u_h.xfer(nb, w, 32'h0000_0000, 1'b1, q);
		u_h.stop();
	endtask : rd

	// ==========
	// Main sequence.
	initial begin
		logic [31:0] q;
		logic        e;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rdc(REG_STATUS, 32'h0007_FFFF, 32'h0000_0000);
		apb(1'b1, 8'h20, 32'h0000_0001, q, e);
		chk("unmapped", {31'h0, e}, 32'h0000_0001);
		rdc(REG_CTRL, 32'hFFFF_FFFF, CTRL_RESET);
		apb(1'b1, REG_MEM_ADDR, 32'h0000_0010, q, e);
		apb(1'b1, REG_MEM_DATA, 32'h0000_00A5, q, e);
		apb(1'b1, REG_MEM_DATA, 32'h0000_003C, q, e);
		rd(1'b1, OP_READ, 1, 0, 1, 16, 8'h00, q);
		chk("read", q, 32'h0000_A53C);
		rd(1'b1, OP_FAST, 1, 8, 1, 8, 8'h00, q);
		chk("fast", q, 32'h0000_00A5);
		rd(1'b1, OP_DOUT, 1, 8, 2, 8, 8'h00, q);
		chk("dual", q, 32'h0000_00A5);
		rd(1'b1, OP_QOUT, 1, 8, 4, 8, 8'h00, q);
		chk("quad_off", {31'h0, seen_oe}, 32'h0000_0000);
		cmd(OP_WREN, 0, 16'h0000);
		cmd(OP_WRSR, 16, 16'h0002);
		u_h.start();
		u_h.xfer(8, 1, 32'(OP_RDSR1), 1'b0, q);
		u_h.xfer(8, 1, 32'h0000_0000, 1'b1, q);
		u_h.stop();
		chk("busy", q, 32'h0000_0003);
		rd(1'b1, OP_READ, 1, 0, 1, 8, 8'h00, q);
		chk("busy_rd", {31'h0, seen_oe}, 32'h0000_0000);
		idle();
		rdc(REG_STATUS, 32'h0000_4303, 32'h0000_0200);
		rd(1'b1, OP_QOUT, 1, 8, 4, 8, 8'h00, q);
		chk("quad", q, 32'h0000_00A5);
		cmd(OP_WREN, 0, 16'h0000);
		cmd(OP_WRSR, 8, 16'h0000);
		idle();
		rdc(REG_STATUS, 32'h0000_4303, 32'h0000_0000);
		cmd(OP_WREN, 0, 16'h0000);
		cmd(OP_WRSR, 12, 16'h0002);
		rdc(REG_STATUS, 32'h0000_0203, 32'h0000_0002);
		cmd(OP_WRDI, 0, 16'h0000);
		cmd(OP_VWREN, 0, 16'h0000);
		rdc(REG_STATUS, 32'h0001_0002, 32'h0001_0000);
		cmd(OP_WRSR, 16, 16'h0002);
		rdc(REG_STATUS, 32'h0000_0203, 32'h0000_0200);
		rd(1'b1, OP_DIO, 2, 0, 2, 8, 8'h2F, q);
		chk("dio", q, 32'h0000_00A5);
		rdc(REG_STATUS, 32'h0002_0000, 32'h0002_0000);
		rd(1'b0, OP_DIO, 2, 0, 2, 8, 8'h0F, q);
		chk("dio_cont", q, 32'h0000_00A5);
		rdc(REG_STATUS, 32'h0002_0000, 32'h0000_0000);
		rd(1'b1, OP_DIO, 2, 0, 2, 8, 8'h2F, q);
		chk("dio_op", q, 32'h0000_00A5);
		cmd(OP_CRMR, 0, 16'h0000);
		rdc(REG_STATUS, 32'h0002_0000, 32'h0000_0000);
		finish_test();
	end
endmodule : sfr_flash_cmd_tb
`default_nettype wire

//--- testbench/sfr_spi_host.sv
// SPI host model: select, link clock in mode 0, and up to four lanes.
// Assumes the bench resolves the lanes from both parties' enables.
`timescale 1ns/1ns
`default_nettype none
module sfr_spi_host
	import sfr_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic [3:0] lane_in,
	output logic            cs_n,
	output logic            sclk,
	output logic [3:0]      h_do,
	output logic [3:0]      h_oe
);
	// ==========
	// Frame tasks; the link clock stands low between frames.
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		h_do = 4'h0;
		h_oe = 4'h0;
	end
	task automatic start();
		@(posedge clk_sys);
		cs_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : start
	// A longer low phase leaves margin for the device's launch delay.
	task automatic xfer(input int n, input int w, input logic [31:0] v,
		input logic rd, output logic [31:0] q);
		logic [3:0] m;
		m = 4'((1 << w) - 1);
		q = 32'h0000_0000;
		for (int c = n - w; c >= 0; c -= w) begin
			@(posedge clk_sys);
			sclk <= 1'b0;
			h_oe <= rd ? 4'h0 : m;
			h_do <= 4'(v >> c) & m;
			repeat (5) @(posedge clk_sys);
			q = (q << w) | ((w == 1) ? 32'(lane_in[1]) : 32'(lane_in & m));
			sclk <= 1'b1;
			repeat (2) @(posedge clk_sys);
		end
	endtask : xfer
	task automatic stop();
		@(posedge clk_sys);
		sclk <= 1'b0;
		h_oe <= 4'h0;
		repeat (5) @(posedge clk_sys);
		cs_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
	endtask : stop
endmodule : sfr_spi_host
`default_nettype wire
